/* srf_bank0_regs.sv */
// bank-0 control register set with reset images and access rules
// assumes a same-clock core on the plain register port and
// same-clock peripherals feeding the read-only counters
//
// Function
// RULE1 - defined reset bits forced at every reset
// RULE2 - undefined reset bits keep their value
// RULE3 - unused bit positions always read zero
// RULE4 - counters and request register ignore writes
// RULE5 - all other registers read and write
// RULE6 - software never targets read-only registers
// RULE7 - software keeps system mode bit five zero
// RULE8 - data registers of timers reset ones
// RULE9 - pointers reset to 11000 and 11001
// RULE10 - port registers zero, port b high ones
// RULE11 - port d data resets to 0c
// RULE12 - flags low two bits cleared
// RULE13 - stack, instruction pointers, mask stay undefined
// RULE14 - system mode resets 0xx xxx00 pattern
// RULE15 - request register reads zero after reset
// RULE16 - listed control registers reset to zero
// RULE17 - four gap locations hold no register
// RULE18 - unmapped reads zero, writes ignored
// RULE19 - reset images applied on any reset
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "srf_bank0_defs.svh"

module srf_bank0_regs
  import srf_pkg::*;
(
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_reset,
  // register port from the core
  input  wire logic [7:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_write,
  input  wire logic                      i_read,
  output logic      [7:0]                o_rdata,
  output logic                           o_read_valid,
  // live counts from the peripherals
  input  wire logic [7:0]                i_timer0_count,
  input  wire logic [7:0]                i_irq_request,
  input  wire logic [7:0]                i_timer1_count_high,
  input  wire logic [7:0]                i_timer1_count_low,
  // register contents toward the peripherals
  output logic      [`SRF_COUNT*8-1:0]   o_bank_image,
  // status
  output logic                           o_ready,
  output logic                           o_ro_write_reject,
  output logic                           o_mode_bit5_write
);

  // access class of each location
  function automatic srf_access_t srf_access(input logic [7:0] a);
    case (a)
      `SRF_OFF_T0_CNT:  return SRF_RO; // [RULE4]
      `SRF_OFF_IRQ_REQ: return SRF_RO; // [RULE4]
      `SRF_OFF_T1_CHI:  return SRF_RO; // [RULE4]
      `SRF_OFF_T1_CLO:  return SRF_RO; // [RULE4]
      `SRF_OFF_T0_DAT,
      `SRF_OFF_T0_CON,
      `SRF_OFF_WDT_CON,
      `SRF_OFF_CLK_CON,
      `SRF_OFF_FLAGS,
      `SRF_OFF_RP_A,
      `SRF_OFF_RP_B,
      `SRF_OFF_SP_LO,
      `SRF_OFF_IP_HI,
      `SRF_OFF_IP_LO,
      `SRF_OFF_IRQ_MSK,
      `SRF_OFF_SYS_MOD,
      `SRF_OFF_PAGE,
      `SRF_OFF_PA_DAT,
      `SRF_OFF_PB_DAT,
      `SRF_OFF_PC_DAT,
      `SRF_OFF_PD_DAT,
      `SRF_OFF_PC_IEN,
      `SRF_OFF_PC_PND,
      `SRF_OFF_PA_PUP,
      `SRF_OFF_PA_CHI,
      `SRF_OFF_PA_CLO,
      `SRF_OFF_PB_CHI,
      `SRF_OFF_PB_CLO,
      `SRF_OFF_PC_CLO,
      `SRF_OFF_PC_PUP,
      `SRF_OFF_PD_CON,
      `SRF_OFF_PA_IEN,
      `SRF_OFF_PA_PND,
      `SRF_OFF_CA_CON,
      `SRF_OFF_CA_DHI,
      `SRF_OFF_CA_DLO,
      `SRF_OFF_T1_DHI,
      `SRF_OFF_T1_DLO:  return SRF_RW; // [RULE5]
      // gaps and anything outside the bank
      default:          return SRF_NONE; // [RULE17] [RULE18]
    endcase
  endfunction : srf_access

  // bits that exist in each location
  function automatic srf_byte_t srf_used(input logic [7:0] a);
    if (srf_access(a) == SRF_NONE) begin
      return `SRF_MASK_NONE; // [RULE18]
    end
    case (a)
      `SRF_OFF_RP_A:    return `SRF_USED_RP; // [RULE3]
      `SRF_OFF_RP_B:    return `SRF_USED_RP; // [RULE3]
      `SRF_OFF_SYS_MOD: return `SRF_USED_MODE; // [RULE3]
      `SRF_OFF_PD_DAT:  return `SRF_USED_PORTD; // [RULE3]
      default:          return `SRF_MASK_ALL;
    endcase
  endfunction : srf_used

  // bits that reset forces to a defined level
  function automatic srf_byte_t srf_rst_mask(input logic [7:0] a);
    case (a)
      `SRF_OFF_FLAGS:   return `SRF_MASK_FLAGS; // [RULE12]
      `SRF_OFF_SP_LO:   return `SRF_MASK_NONE; // [RULE13]
      `SRF_OFF_IP_HI:   return `SRF_MASK_NONE; // [RULE13]
      `SRF_OFF_IP_LO:   return `SRF_MASK_NONE; // [RULE13]
      `SRF_OFF_IRQ_MSK: return `SRF_MASK_NONE; // [RULE13]
      `SRF_OFF_SYS_MOD: return `SRF_MASK_MODE; // [RULE14]
      default:          return `SRF_MASK_ALL; // [RULE1]
    endcase
  endfunction : srf_rst_mask

  // defined reset levels
  function automatic srf_byte_t srf_rst_val(input logic [7:0] a);
    case (a)
      `SRF_OFF_T0_DAT:  return `SRF_RST_ONES; // [RULE8]
      `SRF_OFF_CA_DHI:  return `SRF_RST_ONES; // [RULE8]
      `SRF_OFF_CA_DLO:  return `SRF_RST_ONES; // [RULE8]
      `SRF_OFF_T1_DHI:  return `SRF_RST_ONES; // [RULE8]
      `SRF_OFF_T1_DLO:  return `SRF_RST_ONES; // [RULE8]
      `SRF_OFF_RP_A:    return `SRF_RST_RP_A; // [RULE9]
      `SRF_OFF_RP_B:    return `SRF_RST_RP_B; // [RULE9]
      `SRF_OFF_PB_CHI:  return `SRF_RST_ONES; // [RULE10]
      `SRF_OFF_PD_DAT:  return `SRF_RST_PORTD; // [RULE11]
      // counters, controls, ports, request register
      default:          return `SRF_RST_ZERO; // [RULE10] [RULE15] [RULE16]
    endcase
  endfunction : srf_rst_val

  // array index of a location inside the bank
  function automatic logic [5:0] srf_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `SRF_BASE;
    return d[5:0];
  endfunction : srf_idx

  // location address of an array entry
  function automatic logic [7:0] srf_addr_of(input int i);
    logic [7:0] s;
    s = `SRF_BASE + 8'(i);
    return s;
  endfunction : srf_addr_of

  // register storage, one byte per location
  srf_byte_t regs [0:`SRF_COUNT-1];

  // storage update; undefined bits are simply left alone at reset,
  // which saves reset fan-out on the pointer and mask bytes
  always_ff @(posedge i_clock) begin
    for (int i = 0; i < `SRF_COUNT; i++) begin
      if (i_reset) begin
        // force the defined bits, clear unused bits, keep the rest
        regs[i] <= ((regs[i] & ~srf_rst_mask(srf_addr_of(i)))
                   | (srf_rst_val(srf_addr_of(i))
                      & srf_rst_mask(srf_addr_of(i))))
                   & srf_used(srf_addr_of(i)); // [RULE1] [RULE2] [RULE19]
      end else begin
        case (srf_access(srf_addr_of(i)))
          // read-only: follow the peripheral, never the core
          SRF_RO: begin
            if (srf_addr_of(i) == `SRF_OFF_T0_CNT) begin
              regs[i] <= i_timer0_count; // [RULE4]
            end else if (srf_addr_of(i) == `SRF_OFF_IRQ_REQ) begin
              regs[i] <= i_irq_request; // [RULE4]
            end else if (srf_addr_of(i) == `SRF_OFF_T1_CHI) begin
              regs[i] <= i_timer1_count_high; // [RULE4]
            end else begin
              regs[i] <= i_timer1_count_low; // [RULE4]
            end
          end
          // read/write: take core writes, unused bits dropped
          SRF_RW: begin
            if (i_write && i_addr == srf_addr_of(i)) begin
              regs[i] <= i_wdata & srf_used(srf_addr_of(i)); // [RULE3] [RULE5]
            end
          end
          // gaps hold nothing
          default: begin
            regs[i] <= `SRF_RST_ZERO; // [RULE17]
          end
        endcase
      end
    end
  end

  // flattened image toward the peripherals
  always_comb begin
    for (int i = 0; i < `SRF_COUNT; i++) begin
      o_bank_image[i*8 +: 8] = regs[i];
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= `SRF_RST_ZERO;
    end else if (i_read && srf_access(i_addr) != SRF_NONE) begin
      // mask again so a stray stored bit can never leak out
      o_rdata <= regs[srf_idx(i_addr)] & srf_used(i_addr); // [RULE3]
    end else begin
      o_rdata <= `SRF_RST_ZERO; // [RULE18]
    end
  end

  // read answer marker
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_read_valid <= 1'b0;
    end else begin
      o_read_valid <= i_read;
    end
  end

  // ready goes high on the first edge after reset release
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ready <= 1'b0; // [RULE19]
    end else begin
      o_ready <= 1'b1;
    end
  end

  // a write aimed at a read-only register is reported, not applied
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ro_write_reject <= 1'b0;
    end else begin
      o_ro_write_reject <= i_write && srf_access(i_addr) == SRF_RO; // [RULE6]
    end
  end

  // bit five of system mode is not stored; flag any attempt to set it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_mode_bit5_write <= 1'b0;
    end else begin
      o_mode_bit5_write <= i_write && i_addr == `SRF_OFF_SYS_MOD
                           && i_wdata[`SRF_MODE_HAZARD]; // [RULE7]
    end
  end

  // named views for the checks below
  srf_byte_t chk_t0_dat;
  srf_byte_t chk_rp_a;
  srf_byte_t chk_rp_b;
  srf_byte_t chk_flags;
  srf_byte_t chk_mode;
  srf_byte_t chk_irq;
  srf_byte_t chk_sp_lo;
  srf_byte_t chk_pb_chi;
  srf_byte_t chk_pa_dat;
  srf_byte_t chk_pd_dat;
  srf_byte_t chk_clk;
  srf_byte_t chk_t1_dlo;
  assign chk_t0_dat = regs[srf_idx(`SRF_OFF_T0_DAT)];
  assign chk_rp_a   = regs[srf_idx(`SRF_OFF_RP_A)];
  assign chk_rp_b   = regs[srf_idx(`SRF_OFF_RP_B)];
  assign chk_flags  = regs[srf_idx(`SRF_OFF_FLAGS)];
  assign chk_mode   = regs[srf_idx(`SRF_OFF_SYS_MOD)];
  assign chk_irq    = regs[srf_idx(`SRF_OFF_IRQ_REQ)];
  assign chk_sp_lo  = regs[srf_idx(`SRF_OFF_SP_LO)];
  assign chk_pb_chi = regs[srf_idx(`SRF_OFF_PB_CHI)];
  assign chk_pa_dat = regs[srf_idx(`SRF_OFF_PA_DAT)];
  assign chk_pd_dat = regs[srf_idx(`SRF_OFF_PD_DAT)];
  assign chk_clk    = regs[srf_idx(`SRF_OFF_CLK_CON)];
  assign chk_t1_dlo = regs[srf_idx(`SRF_OFF_T1_DLO)];

  // a reset pulse followed by release
  sequence s_reset_release;
    i_reset ##1 !i_reset;
  endsequence

  // a plain write to a writable location
  sequence s_rw_write;
    i_write && srf_access(i_addr) == SRF_RW;
  endsequence

  chk_timer_data_ones: assert property (@(posedge i_clock) // [RULE8]
    i_reset |=> chk_t0_dat == `SRF_RST_ONES && chk_t1_dlo == `SRF_RST_ONES)
    else $error("timer data not all ones after reset");

  chk_pointer_reset: assert property (@(posedge i_clock) // [RULE9]
    i_reset |=> chk_rp_a == `SRF_RST_RP_A && chk_rp_b == `SRF_RST_RP_B)
    else $error("register pointers wrong after reset");

  chk_port_reset: assert property (@(posedge i_clock) // [RULE10]
    i_reset |=> chk_pb_chi == `SRF_RST_ONES && chk_pa_dat == `SRF_RST_ZERO)
    else $error("port registers wrong after reset");

  chk_portd_reset: assert property (@(posedge i_clock) // [RULE11]
    i_reset |=> chk_pd_dat == `SRF_RST_PORTD)
    else $error("port d data wrong after reset");

  chk_flags_reset: assert property (@(posedge i_clock) // [RULE12]
    i_reset |=> (chk_flags & `SRF_MASK_FLAGS) == `SRF_RST_ZERO)
    else $error("flags low bits not cleared");

  chk_mode_reset: assert property (@(posedge i_clock) // [RULE14]
    i_reset |=> (chk_mode & `SRF_MASK_MODE) == `SRF_RST_ZERO)
    else $error("system mode defined bits not cleared");

  // case equality: a byte that was never written stays unknown, and an
  // unknown that comes through reset unchanged still counts as kept
  chk_undef_kept: assert property (@(posedge i_clock) // [RULE13]
    i_reset |=> chk_sp_lo === $past(chk_sp_lo))
    else $error("stack pointer low changed by reset");

  chk_zero_controls: assert property (@(posedge i_clock) // [RULE16]
    i_reset |=> chk_clk == `SRF_RST_ZERO)
    else $error("clock control not zero after reset");

  chk_irq_after_reset: assert property (@(posedge i_clock) // [RULE15]
    s_reset_release |-> o_rdata == `SRF_RST_ZERO && chk_irq == `SRF_RST_ZERO)
    else $error("request register not zero after reset");

  chk_ready_release: assert property (@(posedge i_clock) // [RULE19]
    s_reset_release |=> o_ready ##1 o_ready)
    else $error("ready not raised after reset release");

  // the checks below rest while reset is held; the reset images
  // themselves are covered by the checks above
  chk_ro_write_ignored: assert property (@(posedge i_clock) // [RULE4]
    disable iff (i_reset)
    i_write && i_addr == `SRF_OFF_IRQ_REQ
    |=> chk_irq == $past(i_irq_request) && o_ro_write_reject)
    else $error("write altered request register");

  chk_rw_write_store: assert property (@(posedge i_clock) // [RULE5]
    disable iff (i_reset)
    s_rw_write ##1 (i_read && i_addr == $past(i_addr) && !i_reset)
    |=> o_rdata == ($past(i_wdata, 2) & srf_used($past(i_addr, 2))))
    else $error("written value not read back");

  chk_unused_zero: assert property (@(posedge i_clock) // [RULE3]
    disable iff (i_reset)
    i_read |=> (o_rdata & ~srf_used($past(i_addr))) == `SRF_RST_ZERO)
    else $error("unused bit read as one");

  chk_unmapped_zero: assert property (@(posedge i_clock) // [RULE18]
    disable iff (i_reset)
    i_read && srf_access(i_addr) == SRF_NONE |=> o_rdata == `SRF_RST_ZERO)
    else $error("unmapped location read nonzero");

  // d8 is the first gap of the bank, eight places above the base
  chk_gap_empty: assert property (@(posedge i_clock) // [RULE17]
    disable iff (i_reset)
    i_write && i_addr == `SRF_OFF_T0_CNT + 8'h08
    |=> regs[srf_idx(`SRF_OFF_T0_CNT + 8'h08)] == `SRF_RST_ZERO)
    else $error("gap location stored data");

  // bit five is never stored, so the stored mode byte must still hold it clear
  chk_mode_hazard: assert property (@(posedge i_clock) // [RULE7]
    disable iff (i_reset)
    i_write && i_addr == `SRF_OFF_SYS_MOD && i_wdata[`SRF_MODE_HAZARD]
    |=> o_mode_bit5_write && !chk_mode[`SRF_MODE_HAZARD])
    else $error("mode bit five hazard not flagged");

endmodule : srf_bank0_regs

`default_nettype wire

/* srf_bank0_defs.svh */
// offsets, reset images and bit masks of the bank-0 control register set
// assumes an 8-bit register-file address space, bank selected elsewhere
`ifndef SRF_BANK0_DEFS_SVH
`define SRF_BANK0_DEFS_SVH
`define SRF_BASE        8'hd0
`define SRF_COUNT       42
`define SRF_OFF_T0_CNT  8'hd0
`define SRF_OFF_T0_DAT  8'hd1
`define SRF_OFF_T0_CON  8'hd2
`define SRF_OFF_WDT_CON 8'hd3
`define SRF_OFF_CLK_CON 8'hd4
`define SRF_OFF_FLAGS   8'hd5
`define SRF_OFF_RP_A    8'hd6
`define SRF_OFF_RP_B    8'hd7
`define SRF_OFF_SP_LO   8'hd9
`define SRF_OFF_IP_HI   8'hda
`define SRF_OFF_IP_LO   8'hdb
`define SRF_OFF_IRQ_REQ 8'hdc
`define SRF_OFF_IRQ_MSK 8'hdd
`define SRF_OFF_SYS_MOD 8'hde
`define SRF_OFF_PAGE    8'hdf
`define SRF_OFF_PA_DAT  8'he0
`define SRF_OFF_PB_DAT  8'he1
`define SRF_OFF_PC_DAT  8'he2
`define SRF_OFF_PD_DAT  8'he3
`define SRF_OFF_PC_IEN  8'he5
`define SRF_OFF_PC_PND  8'he6
`define SRF_OFF_PA_PUP  8'he7
`define SRF_OFF_PA_CHI  8'he8
`define SRF_OFF_PA_CLO  8'he9
`define SRF_OFF_PB_CHI  8'hea
`define SRF_OFF_PB_CLO  8'heb
`define SRF_OFF_PC_CLO  8'hed
`define SRF_OFF_PC_PUP  8'hee
`define SRF_OFF_PD_CON  8'hef
`define SRF_OFF_PA_IEN  8'hf1
`define SRF_OFF_PA_PND  8'hf2
`define SRF_OFF_CA_CON  8'hf3
`define SRF_OFF_CA_DHI  8'hf4
`define SRF_OFF_CA_DLO  8'hf5
`define SRF_OFF_T1_CHI  8'hf6
`define SRF_OFF_T1_CLO  8'hf7
`define SRF_OFF_T1_DHI  8'hf8
`define SRF_OFF_T1_DLO  8'hf9
`define SRF_RST_ZERO    8'h00
`define SRF_RST_ONES    8'hff
`define SRF_RST_RP_A    8'hc0
`define SRF_RST_RP_B    8'hc8
`define SRF_RST_PORTD   8'h0c
`define SRF_MASK_ALL    8'hff
`define SRF_MASK_NONE   8'h00
`define SRF_MASK_FLAGS  8'h03
`define SRF_MASK_MODE   8'h83
`define SRF_USED_RP     8'hf8
`define SRF_USED_MODE   8'h9f
`define SRF_USED_PORTD  8'hbf
`define SRF_MODE_HAZARD 5
`endif

/* srf_pkg.sv */
// types shared by the bank-0 control register set
// assumes nothing beyond a SystemVerilog compiler
package srf_pkg;
  typedef logic [7:0] srf_byte_t;
  typedef enum {SRF_RW, SRF_RO, SRF_NONE} srf_access_t;
endpackage : srf_pkg

/* test_srf_bank0_regs.sv */
// self-checking bench for the bank-0 control register set
// assumes the register port, reset and read-only count inputs of srf_bank0_regs
`timescale 1ns/10ps
`default_nettype none

module test_srf_bank0_regs
  import srf_pkg::*;
;
  localparam int LIMIT = 3000;          // cycle ceiling, under two hundred are needed
  // design ports
  logic              i_clock;
  logic              i_reset;
  srf_byte_t         i_addr;
  srf_byte_t         i_wdata;
  logic              i_write;
  logic              i_read;
  srf_byte_t         o_rdata;
  logic              o_read_valid;
  srf_byte_t         t0_in, irq_in, t1h_in, t1l_in;  // live counts fed in
  logic [42*8-1:0]   o_bank_image;
  logic              o_ready, o_ro_write_reject, o_mode_bit5_write;
  // bench state
  srf_byte_t         mdl [256];         // expected register contents
  srf_byte_t         known [256];       // bits whose value is defined
  srf_byte_t         q_exp [$];         // expected read data, oldest first
  srf_byte_t         q_msk [$];         // defined-bit mask of each note
  logic              rv_pipe, rej_pipe, mode_pipe, rdy_pipe;
  int                err_count, tests_run, cyc, seed;

  srf_bank0_regs DUT (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_read_valid(o_read_valid),
    .i_timer0_count(t0_in), .i_irq_request(irq_in), .i_timer1_count_high(t1h_in),
    .i_timer1_count_low(t1l_in), .o_bank_image(o_bank_image), .o_ready(o_ready),
    .o_ro_write_reject(o_ro_write_reject), .o_mode_bit5_write(o_mode_bit5_write)
  );

  // free-running clock, 50 ns period
  always #25 i_clock = ~i_clock;

  // address classes, worked out independently of the design
  function automatic logic mapped(input srf_byte_t a);
    return a >= 8'hd0 && a <= 8'hf9 && a != 8'hd8 && a != 8'he4 && a != 8'hec && a != 8'hf0;
  endfunction : mapped
  function automatic logic is_ro(input srf_byte_t a);
    return a == 8'hd0 || a == 8'hdc || a == 8'hf6 || a == 8'hf7;
  endfunction : is_ro
  function automatic srf_byte_t used_of(input srf_byte_t a);
    case (a)
      8'hd6, 8'hd7: return 8'hf8;       // pointers, low three bits unused
      8'hde:        return 8'h9f;       // mode bits 6 and 5 unused
      8'he3:        return 8'hbf;       // port d bit 6 unused
      default:      return mapped(a) ? 8'hff : 8'h00;
    endcase
  endfunction : used_of
  function automatic srf_byte_t def_of(input srf_byte_t a);
    case (a)
      8'hd5:                      return 8'h03;
      8'hde:                      return 8'h83;
      8'hd9, 8'hda, 8'hdb, 8'hdd: return 8'h00;
      default:                    return 8'hff;
    endcase
  endfunction : def_of
  function automatic srf_byte_t rst_of(input srf_byte_t a);
    case (a)
      8'hd1, 8'hf4, 8'hf5, 8'hf8, 8'hf9, 8'hea: return 8'hff;
      8'hd6:                                    return 8'hc0;
      8'hd7:                                    return 8'hc8;
      8'he3:                                    return 8'h0c;
      default:                                  return 8'h00;
    endcase
  endfunction : rst_of
  function automatic srf_byte_t exp_of(input srf_byte_t a);
    case (a)
      8'hd0:   return t0_in;
      8'hdc:   return irq_in;
      8'hf6:   return t1h_in;
      8'hf7:   return t1l_in;
      default: return mdl[a] & used_of(a);
    endcase
  endfunction : exp_of
  function automatic srf_byte_t msk_of(input srf_byte_t a);
    return is_ro(a) ? 8'hff : (known[a] | ~used_of(a));
  endfunction : msk_of

  // defined bits forced, undefined bits left as they were
  task automatic reset_model();
    for (int a = 0; a < 256; a++) begin
      mdl[a]   = (mdl[a] & ~def_of(8'(a))) | (rst_of(8'(a)) & def_of(8'(a)));
      known[a] = known[a] | def_of(8'(a));
    end
  endtask : reset_model

  // comparison and report
  task automatic chk(input srf_byte_t seen, input srf_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // bus cycles, each strobe replaced at the next edge by the next call
  task automatic wr(input srf_byte_t a, input srf_byte_t d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_read  <= 1'b0;
    i_addr  <= a;
    i_wdata <= d;
    if (mapped(a) && !is_ro(a)) begin
      mdl[a]   = d;
      known[a] = 8'hff;
    end
  endtask : wr
  task automatic rd(input srf_byte_t a);
    @(posedge i_clock);
    i_read  <= 1'b1;
    i_write <= 1'b0;
    i_addr  <= a;
    q_exp.push_back(exp_of(a));
    q_msk.push_back(msk_of(a));
  endtask : rd
  task automatic idle();
    @(posedge i_clock);
    i_read  <= 1'b0;
    i_write <= 1'b0;
  endtask : idle

  // expected one-cycle outputs, taken from what the bench drove
  always @(posedge i_clock) begin
    cyc       <= cyc + 1;
    rv_pipe   <= i_read & ~i_reset;
    rej_pipe  <= i_write & is_ro(i_addr) & ~i_reset;
    mode_pipe <= i_write & (i_addr == 8'hde) & i_wdata[5] & ~i_reset;
    rdy_pipe  <= ~i_reset;
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  // watcher: outputs are settled at the falling edge
  always @(negedge i_clock) begin
    if (cyc > 0) begin
      chk(8'(o_read_valid), 8'(rv_pipe));
      chk(8'(o_ro_write_reject), 8'(rej_pipe));
      chk(8'(o_mode_bit5_write), 8'(mode_pipe));
      chk(8'(o_ready), 8'(rdy_pipe));
      if (o_read_valid === 1'b1 && q_exp.size() > 0) begin
        chk(o_rdata & q_msk[0], q_exp[0] & q_msk[0]);
        void'(q_exp.pop_front());
        void'(q_msk.pop_front());
      end else if (o_read_valid !== 1'b1) begin
        chk(o_rdata, 8'h00);
      end
    end
  end

  // main sequence
  initial begin
    seed = 92;
    i_clock = 1'b0;
    i_reset = 1'b1;
    {i_addr, i_wdata, i_write, i_read} = '0;
    {t0_in, irq_in, t1h_in, t1l_in} = '0;
    {err_count, tests_run, cyc} = '0;
    for (int a = 0; a < 256; a++) begin
      known[a] = 8'h00;
    end
    reset_model();
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    // reset images, unused bits and gaps read back
    for (int a = 8'hd0; a <= 8'hf9; a++) rd(8'(a));
    rd(8'h10);
    rd(8'hfa);
    // write then read at once, random data, every location
    for (int a = 8'hd0; a <= 8'hf9; a++) begin
      wr(8'(a), 8'($random(seed)));
      rd(8'(a));
    end
    wr(8'hde, 8'h20);
    rd(8'hde);
    idle();
    @(negedge i_clock);
    for (int k = 0; k < 42; k++) begin
      chk(o_bank_image[k*8 +: 8], exp_of(8'(8'hd0 + k)));
    end
    // live counts must come through the read-only places
    @(posedge i_clock);
    t0_in  <= 8'($random(seed));
    irq_in <= 8'($random(seed));
    t1h_in <= 8'($random(seed));
    t1l_in <= 8'($random(seed));
    repeat (2) idle();
    rd(8'hd0);
    wr(8'hdc, 8'h5a);
    rd(8'hdc);
    rd(8'hf6);
    rd(8'hf7);
    // second reset in mid-run: defined bits forced, others retained
    idle();
    @(posedge i_clock);
    i_reset <= 1'b1;
    reset_model();
    @(posedge i_clock);
    @(posedge i_clock);
    i_reset <= 1'b0;
    for (int a = 8'hd0; a <= 8'hf9; a++) rd(8'(a));
    repeat (3) idle();
    chk(8'(q_exp.size()), 8'h00);
    summarize();
  end
endmodule : test_srf_bank0_regs

`default_nettype wire
